// file: verification/flash_boot_ctrl_bench.sv
/*
 flash_boot_ctrl_bench: strap modes, erase sizes, page program, protection.
 assumes the apb slave answers in its own time; the array port is watched only.
*/
`timescale 1ns/100ps
module flash_boot_ctrl_bench;
	import flash_boot_pkg::*;
	typedef struct packed {
		logic [2:0] s;
		logic [1:0] m;
		logic [1:0] z;
		logic [18:0] a;
		logic [3:0] b;
	} row_type;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic cpu_run, fetch_from_flash, fetch_from_boot_rom, ext_rd_req, ext_rd_grant;
	logic [2:0] want;
	logic [ADDR_W-1:0] e_addr, p_base;
	logic [3:0] e_sel;
	logic [1:0] e_size;
	strap_type straps;
	array_port_type array;
	int n_errors = 0;
	int n_checks = 0;
	int n_prog = 0;
	int n_erase = 0;
	// rows: straps, mode, erase size, aligned base, area mask
	row_type rows [10] = '{
		{3'h0, 2'd0, 2'd0, 19'h0, 4'h0}, {3'h1, 2'd0, 2'd0, 19'h0, 4'h0},
		{3'h2, 2'd0, 2'd0, 19'h0, 4'h0}, {3'h3, 2'd0, 2'd0, 19'h0, 4'h0},
		{3'h4, 2'd0, 2'd0, 19'h0, 4'h0}, {3'h5, 2'd0, 2'd0, 19'h0, 4'h0},
		{3'h6, 2'd2, 2'd3, 19'h0, 4'hf}, {3'h7, 2'd1, 2'd0, 19'h68000, 4'h8},
		{3'h7, 2'd1, 2'd1, 19'h60000, 4'h8}, {3'h7, 2'd1, 2'd2, 19'h40000, 4'hc}};

	strap_board board (.pclk(pclk), .presetn(presetn), .want(want), .straps(straps));
	flash_boot_ctrl #(.PROG_WAIT(4), .ERASE_WAIT(8)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mode_strap_a(straps.width_a), .mode_strap_b(straps.width_b),
		.boot_strap(straps.boot), .cpu_run(cpu_run), .fetch_from_flash(fetch_from_flash),
		.fetch_from_boot_rom(fetch_from_boot_rom), .ext_rd_req(ext_rd_req),
		.ext_rd_grant(ext_rd_grant), .array(array));

	function automatic logic [31:0] word(input int i);
		return 32'ha5000000 + i * 32'h00010003;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test;
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// flags and protection settle one clock after busy falls, so read once more
	task automatic wait_idle;
		int k;
		k = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0);
			k++;
		end while (rd[ST_BUSY] !== 1'b0 && k < 100);
		apb(1'b0, OFS_STATUS, 32'h0);
	endtask

	task automatic do_reset(input logic [2:0] s);
		@(posedge pclk);
		presetn <= 1'b0;
		want <= s;
		ext_rd_req <= 1'b1;
		repeat (2) @(posedge pclk);
		check("grant_in_reset", ext_rd_grant, 1'b1);
		check("run_in_reset", cpu_run, 1'b0);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask

	always @(posedge pclk) begin
		if (array.prog_stb === 1'b1) begin
			check("prog_addr", array.addr, p_base + n_prog);
			check("prog_data", array.wdata, word(n_prog));
			n_prog++;
		end
		if (array.erase_stb === 1'b1) begin
			n_erase++;
			e_addr = array.addr;
			e_size = array.size;
			e_sel = array.block_sel;
		end
	end

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	initial begin
		#200000;
		n_errors++;
		end_of_test;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ext_rd_req = 1'b0;
		want = 3'h0;
		p_base = 19'h21000;
		for (int i = 0; i < 10; i++) begin
			do_reset(rows[i].s);
			check("cpu_run", cpu_run, rows[i].m != 2'd0);
			check("from_flash", fetch_from_flash, rows[i].m == 2'd1);
			check("from_rom", fetch_from_boot_rom, rows[i].m == 2'd2);
			apb(1'b0, OFS_MODE, 32'h0);
			check("mode_reg", rd[1:0], rows[i].m);
			if (rows[i].m != 2'd0) begin
				n_erase = 0;
				apb(1'b1, OFS_ADDR, 32'h6abcd);
				apb(1'b1, OFS_CMD, {26'h0, rows[i].z, 4'h2});
				wait_idle;
				check("erase_count", n_erase, 1);
				check("erase_addr", e_addr, rows[i].a);
				check("erase_size", e_size, rows[i].z);
				check("erase_sel", e_sel, rows[i].b);
				check("done", rd[ST_DONE], 1'b1);
				check("mode_held", fetch_from_flash, rows[i].m == 2'd1);
			end
		end
		apb(1'b1, OFS_PAGE_PTR, 32'h0);
		for (int i = 0; i < PAGE_WORDS; i++)
			apb(1'b1, OFS_PAGE_DATA, word(i));
		n_prog = 0;
		n_erase = 0;
		apb(1'b1, OFS_ADDR, {13'h0, p_base});
		apb(1'b1, OFS_CMD, 32'h1);
		apb(1'b1, OFS_CMD, 32'h2);
		wait_idle;
		check("prog_count", n_prog, PAGE_WORDS);
		check("busy_refuse", n_erase, 0);
		check("busy_err", rd[ST_ERR], 1'b1);
		apb(1'b1, OFS_STATUS, 32'h6);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("err_clear", rd[ST_ERR], 1'b0);
		for (int i = 0; i < NUM_AREAS; i++) begin
			check("grant_open", ext_rd_grant, 1'b1);
			apb(1'b1, OFS_ADDR, i << 17);
			apb(1'b1, OFS_CMD, 32'h3);
			apb(1'b0, OFS_STATUS, 32'h0);
			check("prot_bits", rd[7:4], (4'h1 << (i + 1)) - 1);
		end
		check("rsec_on", rd[ST_RSEC], 1'b1);
		check("grant_shut", ext_rd_grant, 1'b0);
		// a block erase inside a protected area must not reach the array
		apb(1'b1, OFS_ADDR, 32'h0);
		apb(1'b1, OFS_CMD, 32'h2);
		apb(1'b1, OFS_CMD, 32'h1);
		repeat (4) @(posedge pclk);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("prot_refuse", n_erase, 0);
		check("prot_prog", n_prog, PAGE_WORDS);
		check("prot_err", rd[ST_ERR], 1'b1);
		apb(1'b1, OFS_CMD, 32'h4);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("prot_kept", rd[7:4], 4'hf);
		wait_idle;
		check("wipe_count", n_erase, 1);
		check("wipe_addr", e_addr, 19'h0);
		check("wipe_size", e_size, 2'd2);
		check("unprot_bits", rd[7:4], 4'hc);
		check("rsec_off", rd[ST_RSEC], 1'b0);
		check("grant_back", ext_rd_grant, 1'b1);
		apb(1'b0, 12'h018, 32'h0);
		check("unmapped_err", err_seen, 1'b1);
		check("unmapped_data", rd, 32'h0);
		end_of_test;
	end
endmodule

// file: verification/strap_board.sv
/*
 strap_board: board side of the mode straps, standing where a board or a
 programmer would; it moves the strap levels only while reset is held.
 assumes the bench picks the wanted pattern while reset is low.
*/
`timescale 1ns/100ps
module strap_board (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] want,
	output flash_boot_pkg::strap_type straps
);
	import flash_boot_pkg::*;
	initial straps = 3'b000;
	// levels change only under reset, so they stand a clock either side of release
	always @(posedge pclk) begin
		if (presetn !== 1'b1) begin
			straps <= want;
		end
	end
endmodule

// file: verilog/flash_boot_ctrl.sv
/*
 flash_boot_ctrl: boot strap capture and mode selection, plus the APB
 controller of the flash array (page buffer, program/erase, protection,
 read security).
 assumes straps are stable one clock around reset release and that the
 flash array itself sits outside on the array port.
*/
// Implementation choices: the APB interface to the registers and the register offsets.
// Function
// - mode chosen from the two width straps and the boot strap at reset
// - straps 1,1,1 at reset release select single-chip mode
// - straps 1,1,0 at reset release select single-boot mode
// - single-chip mode fetches first from internal flash
// - single-boot mode fetches first from the boot ROM loader
// - outside programmer mode, cpu runs in strap mode after reset release
// - flash is four blocks, each written independently
// - cpu reaches the flash over a 32-bit data path
// - programming writes one page of 128 words
// - erase covers 128 KB, 512 KB or 1 MB
// - write protection set per 512 KB area
// - protection cleared per 1 MB region
// - all four areas protected turns on read security automatically
// - removing protection erases the region before protection clears
// - protection is set only by software command
// - accepted program or erase runs on its own to completion
// - no erase suspend; multi-block erase only as whole chip (the code also erases two blocks with a 1 MB erase)
`timescale 1ns/100ps
module flash_boot_ctrl #(
	parameter int PROG_WAIT = flash_boot_pkg::PROG_CYCLES,
	parameter int ERASE_WAIT = flash_boot_pkg::ERASE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mode_strap_a,
	input wire logic mode_strap_b,
	input wire logic boot_strap,
	output logic cpu_run,
	output logic fetch_from_flash,
	output logic fetch_from_boot_rom,
	input wire logic ext_rd_req,
	output logic ext_rd_grant,
	output flash_boot_pkg::array_port_type array
);
	import flash_boot_pkg::*;

	strap_type straps;
	boot_mode_type mode;
	logic captured;
	logic [31:0] page_buf [PAGE_WORDS];
	logic [PTR_W-1:0] page_ptr;
	logic [ADDR_W-1:0] addr_reg;
	flash_op_type last_op;
	erase_size_type last_size;
	logic [NUM_AREAS-1:0] prot;
	logic done_flag;
	logic err_flag;
	logic unprot_pending;
	logic [NUM_AREAS-1:0] unprot_mask;
	logic [ADDR_W-1:0] seq_base;
	erase_size_type seq_size;
	logic seq_erase;
	logic seq_start;
	logic seq_busy;
	logic seq_done;
	logic [PTR_W-1:0] seq_index;

	assign straps = '{width_a: mode_strap_a, width_b: mode_strap_b, boot: boot_strap};

	// strap decode
	wire [2:0] strap_bits = straps;
	wire strap_chip = strap_bits == STRAP_CHIP;
	wire strap_boot = strap_bits == STRAP_BOOT;
	wire boot_mode_type strap_mode = strap_chip ? mode_single_chip :
		strap_boot ? mode_single_boot : mode_none;

	// first edge after release samples the straps, which the board still holds
	// for that clock; reset itself only loads constants
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			captured <= 1'b0;
			mode <= mode_none;
			cpu_run <= 1'b0;
			fetch_from_flash <= 1'b0;
			fetch_from_boot_rom <= 1'b0;
		end else if (!captured) begin
			captured <= 1'b1;
			mode <= strap_mode;
			cpu_run <= strap_mode != mode_none;
			fetch_from_flash <= strap_chip;
			fetch_from_boot_rom <= strap_boot;
		end
	end

	// read security follows protection with no software step
	wire read_secure = &prot;
	assign ext_rd_grant = ext_rd_req && !read_secure;

	// apb decode
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_mode = paddr == OFS_MODE;
	wire hit_cmd = paddr == OFS_CMD;
	wire hit_addr = paddr == OFS_ADDR;
	wire hit_status = paddr == OFS_STATUS;
	wire hit_data = paddr == OFS_PAGE_DATA;
	wire hit_ptr = paddr == OFS_PAGE_PTR;
	wire mapped = hit_mode | hit_cmd | hit_addr | hit_status | hit_data | hit_ptr;
	wire wr = access && pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	wire [31:0] status_word = {23'h0, read_secure, prot, 1'b0, err_flag, done_flag, seq_busy};
	wire [31:0] rd_mux = hit_mode ? {29'h0, captured, mode} :
		hit_cmd ? {26'h0, last_size, 1'b0, last_op} :
		hit_addr ? {13'h0, addr_reg} :
		hit_status ? status_word :
		hit_ptr ? {25'h0, page_ptr} : 32'h0;

	// read data is latched in setup so the access phase needs no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0;
		else if (setup && !pwrite)
			prdata <= rd_mux;
	end

	// command decode
	wire cmd_wr = wr && hit_cmd;
	wire [2:0] cmd_code = pwdata[2:0];
	wire erase_size_type cmd_size = erase_size_type'(pwdata[CMD_SIZE_LSB+1:CMD_SIZE_LSB]);
	wire [NUM_AREAS-1:0] prog_areas = area_mask(addr_reg, size_128k);
	wire [NUM_AREAS-1:0] erase_areas = area_mask(addr_reg, cmd_size);
	wire [NUM_AREAS-1:0] one_mb_areas = area_mask(addr_reg, size_1m);
	wire op_program_ok = cmd_code == op_program && !(|(prog_areas & prot));
	wire op_erase_ok = cmd_code == op_erase && !(|(erase_areas & prot));
	wire cmd_protect = cmd_code == op_protect;
	wire cmd_unprotect = cmd_code == op_unprotect;
	wire cmd_ok = op_program_ok | op_erase_ok | cmd_protect | cmd_unprotect;
	wire cmd_busy = seq_busy || seq_start || unprot_pending;
	wire cmd_take = cmd_wr && !cmd_busy && cmd_ok;
	// refused: busy (no suspend), protected target, or unknown code
	wire cmd_refuse = cmd_wr && (cmd_busy || !cmd_ok);
	wire starts_seq = cmd_take && !cmd_protect;
	wire unprot_finish = seq_done && unprot_pending;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_op <= op_idle;
			last_size <= size_128k;
			seq_start <= 1'b0;
			seq_erase <= 1'b0;
			seq_base <= '0;
			seq_size <= size_128k;
		end else begin
			seq_start <= starts_seq;
			if (cmd_wr) begin
				last_op <= flash_op_type'(cmd_code);
				last_size <= cmd_size;
			end
			if (starts_seq) begin
				seq_erase <= !op_program_ok;
				// unprotect always wipes the whole 1 MB region
				seq_size <= cmd_unprotect ? size_1m : cmd_size;
				seq_base <= op_program_ok ? addr_reg :
					align(addr_reg, cmd_unprotect ? size_1m : cmd_size);
			end
		end
	end

	// protection bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prot <= PROT_RESET;
			unprot_pending <= 1'b0;
			unprot_mask <= 4'h0;
		end else begin
			if (cmd_take && cmd_protect)
				prot <= prot | area_mask(addr_reg, size_512k);
			if (cmd_take && cmd_unprotect) begin
				unprot_pending <= 1'b1;
				unprot_mask <= one_mb_areas;
			end
			// bits clear only once the erase of their region has finished
			if (unprot_finish) begin
				prot <= prot & ~unprot_mask;
				unprot_pending <= 1'b0;
			end
		end
	end

	// sticky flags: hardware set wins over a write-one clear in the same cycle
	wire st_wr = wr && hit_status;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_flag <= 1'b0;
			err_flag <= 1'b0;
		end else begin
			done_flag <= seq_done || (done_flag && !(st_wr && pwdata[ST_DONE]));
			err_flag <= cmd_refuse || (err_flag && !(st_wr && pwdata[ST_ERR]));
		end
	end

	// address and page buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_reg <= '0;
			page_ptr <= '0;
		end else begin
			if (wr && hit_addr)
				addr_reg <= pwdata[ADDR_W-1:0];
			if (wr && hit_ptr)
				page_ptr <= pwdata[PTR_W-1:0];
			else if (wr && hit_data)
				page_ptr <= page_ptr + 1'b1;
		end
	end

	// buffer is not reset; software fills a page before each program
	always_ff @(posedge pclk) begin
		if (wr && hit_data && !seq_busy)
			page_buf[page_ptr] <= pwdata;
	end

	flash_sequencer #(
		.PROG_WAIT(PROG_WAIT),
		.ERASE_WAIT(ERASE_WAIT)
	) u_seq (
		.pclk(pclk),
		.presetn(presetn),
		.start(seq_start),
		.is_erase(seq_erase),
		.base(seq_base),
		.size(seq_size),
		.page_word(page_buf[seq_index]),
		.page_index(seq_index),
		.busy(seq_busy),
		.done(seq_done),
		.array(array)
	);

	// strap checks key on the rise of captured, so the release edge itself is never judged
	chk_chip_select: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(captured) && $past(strap_bits) == 3'b111 |->
		mode == mode_single_chip && fetch_from_flash)
		else $error("single-chip straps did not select flash fetch");
	chk_boot_select: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(captured) && $past(strap_bits) == 3'b110 |->
		mode == mode_single_boot && fetch_from_boot_rom)
		else $error("single-boot straps did not select boot rom fetch");
	chk_no_mode: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(captured) && $past(strap_bits) != 3'b111 && $past(strap_bits) != 3'b110 |->
		mode == mode_none && !cpu_run)
		else $error("other strap levels did not leave the cpu stopped");
	chk_run_needs_mode: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_run |-> captured && mode != mode_none)
		else $error("cpu running without a captured mode");
	chk_mode_held: assert property (@(posedge pclk) disable iff (!presetn)
		captured |=> $stable(mode) && $stable(cpu_run) && captured)
		else $error("mode changed after capture");
	chk_fetch_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
		!(fetch_from_flash && fetch_from_boot_rom) &&
		(cpu_run == (fetch_from_flash || fetch_from_boot_rom)))
		else $error("fetch source inconsistent with run");
	chk_run_release: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(captured) |->
		cpu_run == ($past(strap_bits) == 3'b111 || $past(strap_bits) == 3'b110))
		else $error("cpu run does not follow straps at release");
	chk_read_secure: assert property (@(posedge pclk) disable iff (!presetn)
		prot == 4'hf |-> !ext_rd_grant && status_word[ST_RSEC])
		else $error("flash readable with all areas protected");
	chk_unprot_erase: assert property (@(posedge pclk) disable iff (!presetn)
		|($past(prot) & ~prot) |-> $past(seq_done) && $past(seq_erase))
		else $error("protection cleared without erase");
	chk_busy_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && seq_busy |=> err_flag && !seq_start)
		else $error("command accepted while busy");
	chk_protected_prog: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && cmd_code == 3'h1 && |(prog_areas & prot) && !cmd_busy |=> !seq_start ##1 !seq_busy)
		else $error("program started in protected area");
	chk_erase_protected: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && cmd_code == 3'h2 && |(erase_areas & prot) |=> !seq_start)
		else $error("erase started in protected area");
	chk_protect_sets: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_take && cmd_protect |=> prot[$past(addr_reg[ADDR_W-1:ADDR_W-2])])
		else $error("protect command did not protect its area");
	chk_prot_only_cmd: assert property (@(posedge pclk) disable iff (!presetn)
		|(prot & ~$past(prot)) |-> $past(cmd_take) && $past(cmd_protect))
		else $error("protection set without a protect command");
	chk_wipe_size: assert property (@(posedge pclk) disable iff (!presetn)
		unprot_pending && array.erase_stb |-> array.size == size_1m && array.addr[ADDR_W-2:0] == '0)
		else $error("unprotect wipe is not an aligned 1 MB erase");
	chk_start_runs: assert property (@(posedge pclk) disable iff (!presetn)
		seq_start |=> seq_busy)
		else $error("accepted operation did not start");
	chk_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
		seq_done |=> done_flag)
		else $error("finished operation did not set done");
endmodule

// file: verilog/flash_boot_pkg.sv
/*
 flash_boot_pkg: constants, types and helpers shared by the strap/mode
 logic, the flash controller and its program/erase sequencer.
 assumes a 50 MHz pclk and a 2 MB flash array reached as 32-bit words.
*/
package flash_boot_pkg;
	localparam int CLK_MHZ = 50;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 19;
	localparam int NUM_AREAS = 4;
	localparam int PAGE_WORDS = 128;
	localparam int PTR_W = 7;
	localparam int PROG_TIME_US = 2000;
	localparam int ERASE_TIME_MS = 100;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam logic [11:0] OFS_MODE = 12'h000;
	localparam logic [11:0] OFS_CMD = 12'h004;
	localparam logic [11:0] OFS_ADDR = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam logic [11:0] OFS_PAGE_DATA = 12'h010;
	localparam logic [11:0] OFS_PAGE_PTR = 12'h014;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR = 2;
	localparam int ST_PROT_LSB = 4;
	localparam int ST_RSEC = 8;
	localparam int CMD_SIZE_LSB = 4;
	localparam logic [2:0] STRAP_CHIP = 3'b111;
	localparam logic [2:0] STRAP_BOOT = 3'b110;
	localparam logic [3:0] PROT_RESET = 4'h0;

	typedef enum logic [1:0] {mode_none, mode_single_chip, mode_single_boot} boot_mode_type;
	typedef enum logic [2:0] {op_idle, op_program, op_erase, op_protect, op_unprotect} flash_op_type;
	typedef enum logic [1:0] {size_128k, size_512k, size_1m, size_chip} erase_size_type;

	typedef struct packed {
		logic prog_stb;
		logic erase_stb;
		logic [NUM_AREAS-1:0] block_sel;
		logic [ADDR_W-1:0] addr;
		erase_size_type size;
		logic [DATA_W-1:0] wdata;
	} array_port_type;

	typedef struct packed {
		logic width_a;
		logic width_b;
		logic boot;
	} strap_type;

	// areas touched by an operation at a word address
	function automatic logic [NUM_AREAS-1:0] area_mask(input logic [ADDR_W-1:0] addr,
			input erase_size_type size);
		logic [NUM_AREAS-1:0] m;
		m = 4'h0;
		unique case (size)
			size_128k, size_512k: m = 4'h1 << addr[ADDR_W-1:ADDR_W-2];
			size_1m: m = addr[ADDR_W-1] ? 4'hc : 4'h3;
			size_chip: m = 4'hf;
		endcase
		return m;
	endfunction

	// base address of the region of the given size that holds addr
	function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] addr,
			input erase_size_type size);
		logic [ADDR_W-1:0] a;
		a = addr;
		unique case (size)
			size_128k: a = {addr[ADDR_W-1:15], 15'h0000};
			size_512k: a = {addr[ADDR_W-1:17], 17'h00000};
			size_1m: a = {addr[ADDR_W-1], 18'h00000};
			size_chip: a = 19'h00000;
		endcase
		return a;
	endfunction
endpackage

// file: verilog/flash_sequencer.sv
/*
 flash_sequencer: runs one accepted program or erase to completion on its
 own, streaming a page or sending one erase strobe, then waiting out the array's busy time.
 assumes the caller holds base, size and the page buffer steady while busy.
*/
`timescale 1ns/100ps
module flash_sequencer #(
	parameter int PROG_WAIT = flash_boot_pkg::PROG_CYCLES,
	parameter int ERASE_WAIT = flash_boot_pkg::ERASE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic is_erase,
	input wire logic [flash_boot_pkg::ADDR_W-1:0] base,
	input wire flash_boot_pkg::erase_size_type size,
	input wire logic [flash_boot_pkg::DATA_W-1:0] page_word,
	output logic [flash_boot_pkg::PTR_W-1:0] page_index,
	output logic busy,
	output logic done,
	output flash_boot_pkg::array_port_type array
);
	import flash_boot_pkg::*;

	typedef enum logic [1:0] {s_idle, s_stream, s_wait} seq_state_type;
	seq_state_type state;
	logic [31:0] wait_cnt;
	logic [7:0] stb_count;
	wire last_word = page_index == PTR_W'(PAGE_WORDS - 1);
	wire wait_over = wait_cnt == 32'h0;

	assign busy = state != s_idle;

	// no suspend: once started, the sequence only ends at done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= s_idle;
			page_index <= '0;
			wait_cnt <= 32'h0;
			done <= 1'b0;
			array <= '0;
		end else begin
			done <= 1'b0;
			array.prog_stb <= 1'b0;
			array.erase_stb <= 1'b0;
			unique case (state)
				s_idle: if (start) begin
					page_index <= '0;
					array.size <= size;
					array.block_sel <= area_mask(base, is_erase ? size : size_128k);
					if (is_erase) begin
						array.erase_stb <= 1'b1;
						array.addr <= base;
						wait_cnt <= 32'(ERASE_WAIT - 1);
						state <= s_wait;
					end else begin
						state <= s_stream;
					end
				end
				s_stream: begin
					array.prog_stb <= 1'b1;
					array.addr <= base + ADDR_W'(page_index);
					array.wdata <= page_word;
					page_index <= page_index + 1'b1;
					if (last_word) begin
						wait_cnt <= 32'(PROG_WAIT - 1);
						state <= s_wait;
					end
				end
				s_wait: if (wait_over) begin
					done <= 1'b1;
					state <= s_idle;
				end else begin
					wait_cnt <= wait_cnt - 32'h1;
				end
			endcase
		end
	end

	// helper for checking the page length
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stb_count <= 8'h0;
		else if (start && !busy)
			stb_count <= 8'h0;
		else if (array.prog_stb)
			stb_count <= stb_count + 8'h1;
	end

	chk_page_length: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state == s_wait) && !array.erase_stb |=> stb_count == 8'(PAGE_WORDS))
		else $error("page program did not write exactly one page");
endmodule
